// >>> shared/sie_params.svh
// constants for the subtract instruction execute unit
`ifndef SIE_PARAMS_SVH
`define SIE_PARAMS_SVH

// upper byte of the literal-subtract word
`define SIE_LIT_OPC      8'h08
// top six bits of the file-subtract word
`define SIE_FILE_OPC     6'h17
`define SIE_FILE_OPC_MSB 15
`define SIE_FILE_OPC_LSB 10
// field positions in the file-subtract word
`define SIE_DEST_BIT     9
`define SIE_ABIT         8
// highest offset handled in indexed literal-offset mode
`define SIE_IDX_MAX      8'h5F
// access bank: low offsets map to page 0, the rest to the top page
`define SIE_ACC_SPLIT    8'h60
`define SIE_ACC_LO_PAGE  4'h0
`define SIE_ACC_HI_PAGE  4'hF
// reset values
`define SIE_ACC_RST      8'h00
`define SIE_BYTE_RST     8'h00
`define SIE_ADDR_RST     12'h000

`endif

// >>> shared/sie_pkg.sv
// types of the subtract instruction execute unit
package sie_pkg;

  typedef enum logic [3:0] {
    sie_q1 = 4'h1,
    sie_q2 = 4'h2,
    sie_q3 = 4'h4,
    sie_q4 = 4'h8
  } sie_phase_t;

  typedef struct packed {
    sie_phase_t  phase;
    logic        is_file;
    logic        dest_f;
    logic [7:0]  lit;
    logic [11:0] addr;
    logic [7:0]  opnd;
    logic [7:0]  sub;
    logic [7:0]  result;
    logic [7:0]  acc;
    logic        neg;
    logic        wrap;
    logic        carry;
    logic        half;
    logic        zero;
    logic        illegal;
    logic        done;
  } sie_state_t;

endpackage

// >>> verilog/sie_core.sv
// four-phase execute unit for the two accumulator subtract instructions
//
// How it works
// - literal op writes immediate minus accumulator into the accumulator.
// - literal op decoded from upper byte 08h, immediate in low byte.
// - literal op runs decode, read literal, process, write accumulator.
// - file op subtracts accumulator from addressed byte, two's complement.
// - file op decoded from top six bits, then dest, access, address.
// - dest 0 writes accumulator, dest 1 writes back to the byte.
// - access bit 0 selects the fixed access bank, except in indexed mode.
// - access bit 1 uses bank pointer as upper address bits.
// - access 0, extended set on, offset up to 5Fh uses indexed mode.
// - file op runs decode, read byte, process, write destination.
// - both ops update all five flags; carry means no borrow.
// - negative result kept as two's complement, negative flag set.
`include "sie_params.svh"

module sie_core (
  // clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              sys_rst_in,
  // instruction request
  input  wire logic [15:0]       instr_in,
  input  wire logic              instr_valid_in,
  output logic                   instr_ready_out,
  // accumulator preload
  input  wire logic              acc_load_in,
  input  wire logic [7:0]        acc_load_data_in,
  // addressing context
  input  wire logic              ext_set_en_in,
  input  wire logic [3:0]        bank_select_pointer_in,
  input  wire logic [11:0]       index_base_in,
  // data memory
  output logic [11:0]            mem_addr_out,
  output logic                   mem_rd_out,
  input  wire logic [7:0]        mem_rdata_in,
  output logic                   mem_wr_out,
  output logic [7:0]             mem_wdata_out,
  // accumulator and flags
  output logic [7:0]             acc_out,
  output logic                   neg_flag_out,
  output logic                   signed_wrap_flag_out,
  output logic                   carry_flag_out,
  output logic                   half_byte_carry_flag_out,
  output logic                   zero_flag_out,
  // status
  output sie_pkg::sie_phase_t    phase_out,
  output logic                   done_out,
  output logic                   illegal_out
);
  import sie_pkg::*;

  sie_state_t s_q;
  sie_state_t s_d;

  // {neg, wrap, carry, half, zero} of a minus b
  function automatic logic [4:0] sub_flags(input logic [7:0] a,
                                           input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] nib;
    logic [7:0] r;
    full = {1'b0, a} - {1'b0, b};
    nib  = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    r    = full[7:0];
    sub_flags = {r[7],
                 (a[7] != b[7]) && (r[7] != a[7]),
                 ~full[8],
                 ~nib[4],
                 r == 8'h00};
  endfunction

  // data address from the file-op fields
  function automatic logic [11:0] data_addr(input logic [7:0]  f,
                                            input logic        abit,
                                            input logic        ext,
                                            input logic [3:0]  bank,
                                            input logic [11:0] base);
    if (abit) begin
      data_addr = {bank, f};
    end else if (ext && (f <= `SIE_IDX_MAX)) begin
      data_addr = base + {4'h0, f};
    end else if (f < `SIE_ACC_SPLIT) begin
      data_addr = {`SIE_ACC_LO_PAGE, f};
    end else begin
      data_addr = {`SIE_ACC_HI_PAGE, f};
    end
  endfunction

  logic       is_lit_w;
  logic       is_file_w;
  logic       take_w;
  logic [4:0] flags_w;

  assign is_lit_w  = instr_in[15:8] == `SIE_LIT_OPC;
  assign is_file_w = instr_in[`SIE_FILE_OPC_MSB:`SIE_FILE_OPC_LSB]
                     == `SIE_FILE_OPC;
  assign take_w    = (s_q.phase == sie_q1) && instr_valid_in;
  assign flags_w   = sub_flags(s_q.opnd, s_q.acc);

  always_comb begin
    s_d         = s_q;
    s_d.illegal = 1'b0;
    s_d.done    = 1'b0;
    case (s_q.phase)
      // decode: latch fields, resolve the data address
      sie_q1: begin
        if (take_w && (is_lit_w || is_file_w)) begin
          s_d.phase   = sie_q2;
          s_d.is_file = is_file_w;
          s_d.dest_f  = is_file_w && instr_in[`SIE_DEST_BIT];
          s_d.lit     = instr_in[7:0];
          s_d.addr    = data_addr(instr_in[7:0], instr_in[`SIE_ABIT],
                                  ext_set_en_in, bank_select_pointer_in,
                                  index_base_in);
        end else if (take_w) begin
          // unknown words are dropped, the unit stays in decode
          s_d.illegal = 1'b1;
        end else if (acc_load_in) begin
          s_d.acc = acc_load_data_in;
        end
      end
      // read: literal or addressed byte
      sie_q2: begin
        s_d.phase = sie_q3;
        s_d.opnd  = s_q.is_file ? mem_rdata_in : s_q.lit;
      end
      // process
      sie_q3: begin
        s_d.phase  = sie_q4;
        s_d.sub    = s_q.acc;
        s_d.result = s_q.opnd - s_q.acc;
        s_d.neg    = flags_w[4];
        s_d.wrap   = flags_w[3];
        s_d.carry  = flags_w[2];
        s_d.half   = flags_w[1];
        s_d.zero   = flags_w[0];
      end
      // write destination
      sie_q4: begin
        s_d.phase = sie_q1;
        s_d.done  = 1'b1;
        if (!s_q.dest_f) begin
          s_d.acc = s_q.result;
        end
      end
      default: begin
        s_d.phase = sie_q1;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      s_q         <= '0;
      s_q.phase   <= sie_q1;
      s_q.lit     <= `SIE_BYTE_RST;
      s_q.addr    <= `SIE_ADDR_RST;
      s_q.acc     <= `SIE_ACC_RST;
      s_q.result  <= `SIE_BYTE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // memory write is a strobe in the write phase; data is the held result
  assign instr_ready_out          = s_q.phase == sie_q1;
  assign mem_addr_out             = s_q.addr;
  assign mem_rd_out               = (s_q.phase == sie_q2) && s_q.is_file;
  assign mem_wr_out               = (s_q.phase == sie_q4) && s_q.dest_f;
  assign mem_wdata_out            = s_q.result;
  assign acc_out                  = s_q.acc;
  assign neg_flag_out             = s_q.neg;
  assign signed_wrap_flag_out     = s_q.wrap;
  assign carry_flag_out           = s_q.carry;
  assign half_byte_carry_flag_out = s_q.half;
  assign zero_flag_out            = s_q.zero;
  assign phase_out                = s_q.phase;
  assign done_out                 = s_q.done;
  assign illegal_out              = s_q.illegal;

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence four_phases;
    phase_out == sie_q2 ##1 phase_out == sie_q3 ##1
    phase_out == sie_q4 ##1 phase_out == sie_q1;
  endsequence

  a_phase_walk: assert property (
    take_w && (is_lit_w || is_file_w) |=> four_phases
  ) else $error("phase sequence broken");

  a_bad_word: assert property (
    take_w && !is_lit_w && !is_file_w |=> illegal_out
      && phase_out == sie_q1
  ) else $error("unknown word not refused");

  a_lit_acc: assert property (
    take_w && is_lit_w |-> ##4 done_out
      && acc_out == $past(instr_in[7:0], 4) - $past(acc_out, 4)
  ) else $error("literal result wrong");

  a_result_value: assert property (
    done_out |-> mem_wdata_out == s_q.opnd - s_q.sub
  ) else $error("difference wrong");

  a_dest_acc: assert property (
    phase_out == sie_q4 && !s_q.dest_f |-> !mem_wr_out
      ##1 acc_out == mem_wdata_out
  ) else $error("accumulator destination wrong");

  a_dest_file: assert property (
    phase_out == sie_q4 && s_q.dest_f |-> mem_wr_out
      ##1 $stable(acc_out)
  ) else $error("file destination wrong");

  a_bank_addr: assert property (
    take_w && is_file_w && instr_in[`SIE_ABIT] |=>
      mem_addr_out == {$past(bank_select_pointer_in), $past(instr_in[7:0])}
  ) else $error("banked address wrong");

  a_indexed_addr: assert property (
    take_w && is_file_w && !instr_in[`SIE_ABIT] && ext_set_en_in
      && instr_in[7:0] <= `SIE_IDX_MAX |=>
      mem_addr_out == $past(index_base_in) + {4'h0, $past(instr_in[7:0])}
  ) else $error("indexed address wrong");

  a_access_addr: assert property (
    take_w && is_file_w && !instr_in[`SIE_ABIT] && !ext_set_en_in |=>
      mem_addr_out[7:0] == $past(instr_in[7:0])
      && mem_addr_out[11:8] == (mem_addr_out[7:0] < `SIE_ACC_SPLIT ?
         `SIE_ACC_LO_PAGE : `SIE_ACC_HI_PAGE)
  ) else $error("access bank address wrong");

  a_sign_zero: assert property (
    done_out |-> zero_flag_out == (mem_wdata_out == 8'h00)
      && neg_flag_out == mem_wdata_out[7]
      && (s_q.opnd >= s_q.sub || (!carry_flag_out && !zero_flag_out))
  ) else $error("sign or zero flag wrong");

  a_borrow_flags: assert property (
    done_out |-> carry_flag_out == (s_q.opnd >= s_q.sub)
      && half_byte_carry_flag_out == (s_q.opnd[3:0] >= s_q.sub[3:0])
  ) else $error("carry flags wrong");

  a_wrap_flag: assert property (
    done_out |-> signed_wrap_flag_out ==
      ((s_q.opnd[7] != s_q.sub[7]) && (mem_wdata_out[7] != s_q.opnd[7]))
  ) else $error("signed wrap flag wrong");

  a_file_read: assert property (
    take_w && is_file_w |=> mem_rd_out && !mem_wr_out
  ) else $error("file read strobe missing");

  a_file_operand: assert property (
    phase_out == sie_q2 && s_q.is_file |=> s_q.opnd == $past(mem_rdata_in)
  ) else $error("file operand not taken from memory");

  a_lit_operand: assert property (
    phase_out == sie_q2 && !s_q.is_file |=> s_q.opnd == $past(s_q.lit)
  ) else $error("literal operand wrong");

  a_lit_no_mem: assert property (
    take_w && is_lit_w |=> !mem_rd_out ##2 !mem_wr_out
  ) else $error("literal op touched memory");

  a_dest_bit: assert property (
    take_w && is_file_w |-> ##3
      mem_wr_out == $past(instr_in[`SIE_DEST_BIT], 3)
  ) else $error("write strobe does not follow dest bit");

  a_unknown_quiet: assert property (
    take_w && !is_lit_w && !is_file_w |=> $stable(acc_out)
      && !mem_rd_out && !mem_wr_out
  ) else $error("unknown word had an effect");

  // flags move only on the edge that ends the process phase
  a_flags_hold: assert property (
    phase_out != sie_q3 |=> $stable({neg_flag_out, signed_wrap_flag_out,
      carry_flag_out, half_byte_carry_flag_out, zero_flag_out})
  ) else $error("flags changed outside process phase");

  a_acc_busy: assert property (
    phase_out == sie_q2 || phase_out == sie_q3 |=> $stable(acc_out)
  ) else $error("accumulator changed mid instruction");

  a_sub_taken: assert property (
    phase_out == sie_q3 |=> s_q.sub == $past(acc_out)
  ) else $error("subtrahend is not the accumulator");

  a_acc_preload: assert property (
    instr_ready_out && !instr_valid_in && acc_load_in |=>
      acc_out == $past(acc_load_data_in)
  ) else $error("accumulator preload lost");

  c_lit_op: cover property (take_w && is_lit_w ##4 done_out);
  c_file_wb: cover property (mem_wr_out);
  c_unknown: cover property (illegal_out);
  c_negative: cover property (done_out && neg_flag_out);
  c_indexed: cover property (take_w && is_file_w && ext_set_en_in
                             && !instr_in[`SIE_ABIT]);

endmodule // sie_core

// >>> verification/subtract_instruction_exec_test.sv
// self-checking bench of the subtract execute unit
`include "sie_params.svh"

module subtract_instruction_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sie_pkg::*;

  logic        core_clk, sys_rst, valid, ready, acc_load, ext;
  logic [15:0] instr;
  logic [7:0]  acc_ld_d, rdata, wdata, acc;
  logic [3:0]  bank_select_pointer;
  logic [11:0] base, mem_addr, rd_addr;
  logic        mem_rd, mem_wr, neg, wrap, carry, half, zero, done, illegal;
  sie_phase_t  phase;
  logic [7:0]  mem [4096];
  logic [7:0]  m_acc;
  logic [15:0] lit_tab [8];
  int          failures, n_checks, n_rd, n_wr, i;

  sie_core i_dut (
    .core_clk_in(core_clk), .sys_rst_in(sys_rst),
    .instr_in(instr), .instr_valid_in(valid), .instr_ready_out(ready),
    .acc_load_in(acc_load), .acc_load_data_in(acc_ld_d),
    .ext_set_en_in(ext), .bank_select_pointer_in(bank_select_pointer),
    .index_base_in(base), .mem_addr_out(mem_addr), .mem_rd_out(mem_rd),
    .mem_rdata_in(rdata), .mem_wr_out(mem_wr), .mem_wdata_out(wdata),
    .acc_out(acc), .neg_flag_out(neg), .signed_wrap_flag_out(wrap),
    .carry_flag_out(carry), .half_byte_carry_flag_out(half),
    .zero_flag_out(zero), .phase_out(phase), .done_out(done),
    .illegal_out(illegal));

  // unread cycles see inverted data so a stale sample is caught
  assign rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];

  always @(posedge core_clk) begin
    if (mem_rd) begin
      rd_addr <= mem_addr;
      n_rd <= n_rd + 1;
    end
    if (mem_wr) begin
      mem[mem_addr] <= wdata;
      n_wr <= n_wr + 1;
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic set_acc(input logic [7:0] v);
    acc_load = 1'b1;
    acc_ld_d = v;
    @(posedge core_clk);
    #1;
    acc_load = 1'b0;
    m_acc = v;
    chk({4'h0, acc}, {4'h0, v}, "preload");
  endtask

  // issue one word; returns one step after the done cycle's edge
  task automatic exec(input logic [15:0] w);
    logic [11:0] a;
    logic [7:0]  op, r;
    logic        lit, fil, bad, to_acc;
    int          n;
    lit = (w[15:8] == `SIE_LIT_OPC);
    fil = (w[15:10] == `SIE_FILE_OPC);
    bad = !(lit || fil);
    to_acc = lit || !w[`SIE_DEST_BIT];
    if (w[`SIE_ABIT])
      a = {bank_select_pointer, w[7:0]};
    else if (ext && w[7:0] <= `SIE_IDX_MAX)
      a = base + {4'h0, w[7:0]};
    else if (w[7:0] < `SIE_ACC_SPLIT)
      a = {`SIE_ACC_LO_PAGE, w[7:0]};
    else
      a = {`SIE_ACC_HI_PAGE, w[7:0]};
    op = lit ? w[7:0] : mem[a];
    r = op - m_acc;
    n_rd = 0;
    n_wr = 0;
    instr = w;
    valid = 1'b1;
    // a preload offered with the word must lose to the word
    acc_load = 1'b1;
    acc_ld_d = ~m_acc;
    @(posedge core_clk);
    #1;
    acc_load = 1'b0;
    chk({11'h0, illegal}, {11'h0, bad}, "illegal pulse");
    chk({11'h0, ready}, {11'h0, bad}, "ready after take");
    chk({8'h0, bad ? sie_q1 : sie_q2}, {8'h0, phase}, "phase");
    if (bad) begin
      valid = 1'b0;
      @(posedge core_clk);
      #1;
      chk({4'h0, acc}, {4'h0, m_acc}, "acc after unknown");
      chk(12'(n_wr + n_rd), 12'h000, "mem after unknown");
      return;
    end
    // a request while busy must be ignored
    instr = ~w;
    @(posedge core_clk);
    #1;
    @(posedge core_clk);
    #1;
    valid = 1'b0;
    // n counts edges from the taking one, which is the first
    for (n = 3; n < 8 && done !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    if (done !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t no done", $time);
      tally_and_finish();
    end
    chk(12'(n), 12'h004, "latency");
    chk({11'h0, ready}, 12'h001, "ready at done");
    chk({8'h0, phase}, {8'h0, sie_q1}, "phase at done");
    chk({7'h0, neg, wrap, carry, half, zero},
        {7'h0, r[7], (op[7] ^ m_acc[7]) & (r[7] ^ op[7]),
         op >= m_acc, op[3:0] >= m_acc[3:0], r == 8'h00},
        "flags");
    if (to_acc)
      m_acc = r;
    else
      chk({4'h0, mem[a]}, {4'h0, r}, "byte result");
    chk({4'h0, acc}, {4'h0, m_acc}, "acc result");
    chk(12'(n_wr), to_acc ? 12'h000 : 12'h001, "writes");
    chk(12'(n_rd), {11'h0, fil}, "reads");
    if (fil)
      chk(rd_addr, a, "address");
  endtask

  initial begin
    sys_rst = 1'b1;
    valid = 1'b0;
    instr = 16'h0000;
    acc_load = 1'b0;
    acc_ld_d = 8'h00;
    ext = 1'b0;
    bank_select_pointer = 4'h0;
    base = 12'h000;
    failures = 0;
    n_checks = 0;
    m_acc = 8'h00;
    // acc in upper byte, literal in lower
    lit_tab = '{16'h0102, 16'h0202, 16'h0302, 16'h00FF,
                16'hFF00, 16'h0180, 16'h807F, 16'h1101};
    void'($urandom(32'h11a8));
    for (i = 0; i < 4096; i++)
      mem[i] = 8'($urandom);
    repeat (12) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    chk({4'h0, acc}, 12'h000, "acc reset");
    for (i = 0; i < 8; i++) begin
      set_acc(lit_tab[i][15:8]);
      exec({`SIE_LIT_OPC, lit_tab[i][7:0]});
    end
    exec({`SIE_FILE_OPC, 2'b10, 8'h5F});
    exec({`SIE_FILE_OPC, 2'b00, 8'h60});
    ext = 1'b1;
    base = 12'h7F0;
    exec({`SIE_FILE_OPC, 2'b10, 8'h5F});
    exec({`SIE_FILE_OPC, 2'b10, 8'h60});
    bank_select_pointer = 4'hA;
    exec({`SIE_FILE_OPC, 2'b01, 8'h33});
    exec(16'h5810);
    exec(16'h0900);
    for (i = 0; i < 300; i++) begin
      ext = 1'($urandom);
      bank_select_pointer = 4'($urandom);
      base = 12'($urandom);
      if ($urandom % 4 == 0)
        set_acc(8'($urandom));
      case ($urandom % 3)
        0: exec({`SIE_LIT_OPC, 8'($urandom)});
        1: exec({`SIE_FILE_OPC, 10'($urandom)});
        default: exec(16'($urandom));
      endcase
    end
    tally_and_finish();
  end
endmodule // subtract_instruction_exec_test
